// ---- design/scc_defines.svh ----
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH
// ----------------------------------------
// bus address and command codes
// ----------------------------------------
`define SCC_SLAVE_ADDR 7'h09
`define SCC_CMD_OPT 8'h12
`define SCC_CMD_CUR 8'h14
`define SCC_CMD_VOLT 8'h15
`define SCC_CMD_INCUR 8'h3f
`define SCC_CMD_MAKER 8'hfe
`define SCC_CMD_PART 8'hff
// ----------------------------------------
// reset values and writable field masks
// ----------------------------------------
`define SCC_OPT_RST 16'h7904
`define SCC_CUR_RST 16'h0000
`define SCC_VOLT_RST 16'h0000
`define SCC_INCUR_RST 16'h1000
`define SCC_CUR_MASK 16'h1fc0
`define SCC_VOLT_MASK 16'h7ff0
`define SCC_INCUR_MASK 16'h1f80
`define SCC_CUR_MIN_CODE 7'h02
// ----------------------------------------
// field positions
// ----------------------------------------
`define SCC_OPT_DEGL 15
`define SCC_OPT_WD_HI 14
`define SCC_OPT_WD_LO 13
`define SCC_OPT_LEARN 6
`define SCC_OPT_INHIBIT 0
`define SCC_CUR_HI 12
`define SCC_CUR_LO 6
// ----------------------------------------
// timing
// ----------------------------------------
`define SCC_CLK_NS 4
`define SCC_TICK_NS 1000000
`define SCC_TICK_CYCLES (`SCC_TICK_NS / `SCC_CLK_NS)
`define SCC_DEGL_SHORT_MS 150
`define SCC_DEGL_LONG_MS 1300
`define SCC_WD1_S 44
`define SCC_WD2_S 88
`define SCC_WD3_S 175
`define SCC_DEGL_SHORT_TK (18'(`SCC_DEGL_SHORT_MS))
`define SCC_DEGL_LONG_TK (18'(`SCC_DEGL_LONG_MS))
`define SCC_WD1_TK (18'(`SCC_WD1_S * 1000))
`define SCC_WD2_TK (18'(`SCC_WD2_S * 1000))
`define SCC_WD3_TK (18'(`SCC_WD3_S * 1000))
`endif

// ---- design/scc_pkg.sv ----
package scc_pkg;
  // ----------------------------------------
  // bus engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h2,
    ST_TX = 3'h3,
    ST_TXACK = 3'h4,
    ST_TXLD = 3'h5
  } scc_state_t;
  // ----------------------------------------
  // register contents seen by the converter
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] charger_option_word;
    logic [15:0] charge_current_setting;
    logic [15:0] charge_voltage_setting;
    logic [15:0] input_current_setting;
  } scc_settings_t;
  // power path controls
  typedef struct packed {
    logic adapter_present_flag;
    logic adapter_switch;
    logic battery_switch;
    logic charge_enable;
  } scc_power_t;
endpackage

// ---- design/scc_timer.sv ----
`timescale 1ns/1ps
`include "scc_defines.svh"
// tick counting timer with sticky expiry
module scc_timer (
  input wire logic ref_clk,
  input wire logic rst_sync_b,
  input wire logic tick,
  input wire logic restart,
  input wire logic enable,
  input wire logic [17:0] limit,
  output logic expired
);
  import scc_pkg::*;
  logic [17:0] cnt_q, cnt_d; // elapsed ticks
  logic exp_q, exp_d; // limit reached
  // ----------------------------------------
  // next count
  // ----------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (restart || !enable) begin
      cnt_d = 18'h0;
      exp_d = 1'b0;
    end else if (tick && !exp_q) begin
      // stop at the limit, so expiry holds until restarted
      cnt_d = cnt_q + 18'h1;
      if (cnt_q + 18'h1 >= limit) begin
        exp_d = 1'b1;
      end
    end
  end
  // registers
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cnt_q <= 18'h0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end
  assign expired = exp_q;
endmodule

// ---- design/scc_top.sv ----
`timescale 1ns/1ps
`include "scc_defines.svh"
// Overview of operation
// RL1: slave only, fixed address, never initiates
// RL2: only word read and word write
// RL3: respond only with supply and adapter valid
// RL4: detect start and stop conditions
// RL5: msb first bytes, sample on rise
// RL6: ninth clock carries acknowledge low
// RL7: write word sequence, ack every byte
// RL8: read word sequence, low then high
// RL9: option register 0x12, resets 0x7904
// RL10: charge current 0x14, resets zero
// RL11: charge voltage 0x15, resets zero
// RL12: input current 0x3f, resets 0x1000
// RL13: two fixed read-only identity words
// RL14: option bit 15 picks deglitch time
// RL15: first adapter connection uses short deglitch
// RL16: option bits 14:13 set watchdog period
// RL17: current or voltage write restarts watchdog
// RL18: watchdog expiry suspends charging
// RL19: current or voltage write resumes charging
// RL20: option bits 12:11 pick depletion threshold
// RL21: learn depletion swaps battery to adapter
// RL22: option bit 6 runs learn, self-clears
// RL23: out-of-range current clears, stops charging
// RL24: word commits after high byte ack
// RL25: identity words ignore writes
module scc_top #(
  parameter int TICK_CYCLES = `SCC_TICK_CYCLES,
  parameter logic [15:0] MAKER_ID = 16'h5a01, // arbitrary value
  parameter logic [15:0] PART_ID = 16'h00c3 // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  input wire logic supply_valid,
  input wire logic adapter_detect_input,
  input wire logic battery_below_depletion,
  output scc_pkg::scc_settings_t settings,
  output scc_pkg::scc_power_t power
);
  import scc_pkg::*;
  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_q; // reset release chain
  logic rst_sync_b; // released reset
  logic [4:0] s1_q; // first stage, read only by s2
  logic [4:0] s2_q; // synchronised pins
  logic scl_p_q, sda_p_q; // previous samples for edges
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_q[1];
  // pins are asynchronous to ref_clk, two flops each
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s1_q <= 5'h18;
      s2_q <= 5'h18;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      s1_q <= {scl_pin, sda_pin_in, supply_valid, adapter_detect_input,
               battery_below_depletion};
      s2_q <= s1_q;
      scl_p_q <= s2_q[4];
      sda_p_q <= s2_q[3];
    end
  end
  logic scl_s, sda_s, det_s, below_s, bus_en;
  assign scl_s = s2_q[4];
  assign sda_s = s2_q[3];
  assign det_s = s2_q[1];
  assign below_s = s2_q[0];
  assign bus_en = s2_q[2] & s2_q[1]; // see RL3
  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  // sda moving while scl stays high marks the frame edges
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s; // see RL4
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s; // see RL4
  // ----------------------------------------
  // register read decode
  // ----------------------------------------
  logic [15:0] opt_q, opt_d, cur_q, cur_d, volt_q, volt_d, inc_q, inc_d;
  function automatic logic [15:0] rd_word(input logic [7:0] c, input logic [15:0] o,
                                          input logic [15:0] ci, input logic [15:0] v,
                                          input logic [15:0] ic);
    case (c)
      `SCC_CMD_OPT: rd_word = o;
      `SCC_CMD_CUR: rd_word = ci;
      `SCC_CMD_VOLT: rd_word = v;
      `SCC_CMD_INCUR: rd_word = ic;
      `SCC_CMD_MAKER: rd_word = MAKER_ID; // see RL13
      `SCC_CMD_PART: rd_word = PART_ID; // see RL13
      default: rd_word = 16'h0000;
    endcase
  endfunction
  // ----------------------------------------
  // bus engine
  // ----------------------------------------
  scc_state_t st_q, st_d;
  logic [3:0] bit_q, bit_d; // bits moved in this byte
  logic [2:0] byte_q, byte_d; // 0 addr, 1 cmd, 2 low, 3 high
  logic [7:0] shift_q, shift_d; // byte shifter
  logic [7:0] cmd_q, cmd_d; // command byte
  logic [7:0] lo_q, lo_d; // low data byte held until commit
  logic rw_q, rw_d; // read direction of this address
  logic txb_q, txb_d; // high byte being sent
  logic oe_q, oe_d; // pulling sda low
  logic wr_fire; // whole word received and acknowledged
  logic [15:0] wr_data;
  logic [15:0] rd_now; // word the current command selects
  assign rd_now = rd_word(cmd_q, opt_q, cur_q, volt_q, inc_q);
  // next state of the serial engine
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    byte_d = byte_q;
    shift_d = shift_q;
    cmd_d = cmd_q;
    lo_d = lo_q;
    rw_d = rw_q;
    txb_d = txb_q;
    oe_d = oe_q;
    if (!bus_en || stop_ev) begin
      // never drive when idle or disabled, we only answer
      st_d = ST_IDLE; // see RL1
      oe_d = 1'b0;
    end else if (start_ev) begin
      // repeated start also lands here
      st_d = ST_RX; // see RL4
      bit_d = 4'h0;
      byte_d = 3'h0;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        ST_RX: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s}; // see RL5
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            st_d = ST_ACK;
            oe_d = 1'b1; // see RL6
            case (byte_q)
              3'h0: begin
                rw_d = shift_q[0];
                if (shift_q[7:1] != `SCC_SLAVE_ADDR) begin
                  // other address: stay silent
                  st_d = ST_IDLE; // see RL1
                  oe_d = 1'b0;
                end
              end
              3'h1: cmd_d = shift_q;
              3'h2: lo_d = shift_q;
              3'h3: ; // high byte stays in the shifter for commit
              default: begin
                // a fifth byte is no word protocol: refuse it
                st_d = ST_IDLE; // see RL2
                oe_d = 1'b0;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            byte_d = byte_q + 3'h1;
            if (byte_q == 3'h0 && rw_q) begin
              st_d = ST_TX; // see RL8
              txb_d = 1'b0;
              shift_d = rd_now[7:0];
              oe_d = ~rd_now[7];
            end else begin
              st_d = ST_RX; // see RL7
              oe_d = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_d = bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == 4'h8) begin
              st_d = ST_TXACK;
              oe_d = 1'b0;
            end else begin
              // change sda only while scl is low
              shift_d = {shift_q[6:0], 1'b0}; // see RL5
              oe_d = ~shift_q[6];
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            // host acks the low byte, naks the high byte
            st_d = (!sda_s && !txb_q) ? ST_TXLD : ST_IDLE; // see RL8
          end
        end
        ST_TXLD: begin
          if (scl_fall) begin
            st_d = ST_TX;
            bit_d = 4'h0;
            txb_d = 1'b1;
            shift_d = rd_now[15:8];
            oe_d = ~rd_now[15];
          end
        end
        default: begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end
  // registers of the serial engine
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      byte_q <= 3'h0;
      shift_q <= 8'h00;
      cmd_q <= 8'h00;
      lo_q <= 8'h00;
      rw_q <= 1'b0;
      txb_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      shift_q <= shift_d;
      cmd_q <= cmd_d;
      lo_q <= lo_d;
      rw_q <= rw_d;
      txb_q <= txb_d;
      oe_q <= oe_d;
    end
  end
  assign sda_pin_out = 1'b0; // open drain: only ever pulls low
  assign sda_pin_oe = oe_q;
  // commit only at the end of the high byte's ack clock
  assign wr_fire = (st_q == ST_ACK) && scl_fall && (byte_q == 3'h3) && !rw_q
                   && bus_en && !stop_ev && !start_ev; // see RL24
  assign wr_data = {shift_q, lo_q};
  function automatic logic hit(input logic f, input logic [7:0] c, input logic [7:0] k);
    hit = f && (c == k);
  endfunction
  // ----------------------------------------
  // time base and timers
  // ----------------------------------------
  logic [17:0] tick_q, tick_d; // one millisecond divider
  logic tick;
  logic wd_restart, wd_exp, degl_exp;
  logic [17:0] wd_limit, degl_limit;
  logic cycled_q, cycled_d; // adapter switch has been on then off
  assign tick = (tick_q == 18'(TICK_CYCLES - 1));
  assign wd_restart = hit(wr_fire, cmd_q, `SCC_CMD_CUR) |
                      hit(wr_fire, cmd_q, `SCC_CMD_VOLT); // see RL17
  // period select, 00 turns the watchdog off
  always_comb begin
    case (opt_q[`SCC_OPT_WD_HI:`SCC_OPT_WD_LO])
      2'h1: wd_limit = `SCC_WD1_TK; // see RL16
      2'h2: wd_limit = `SCC_WD2_TK;
      default: wd_limit = `SCC_WD3_TK;
    endcase
  end
  // the long deglitch waits until the switch has cycled once
  assign degl_limit = (opt_q[`SCC_OPT_DEGL] && cycled_q) ?
                      `SCC_DEGL_LONG_TK : `SCC_DEGL_SHORT_TK; // see RL14 see RL15
  scc_timer u_wd (
    .ref_clk(ref_clk),
    .rst_sync_b(rst_sync_b),
    .tick(tick),
    .restart(wd_restart),
    .enable(opt_q[`SCC_OPT_WD_HI:`SCC_OPT_WD_LO] != 2'h0),
    .limit(wd_limit),
    .expired(wd_exp)
  );
  // rising edge deglitch; a dropped adapter restarts the count
  scc_timer u_degl (
    .ref_clk(ref_clk),
    .rst_sync_b(rst_sync_b),
    .tick(tick),
    .restart(~det_s),
    .enable(1'b1),
    .limit(degl_limit),
    .expired(degl_exp)
  );
  // ----------------------------------------
  // command registers and power path
  // ----------------------------------------
  logic adapter_present_flag_q, adapter_present_flag_d, acsw_q, acsw_d, chg_q, chg_d;
  logic cur_ok; // written current inside 128 mA .. 8.128 A
  assign cur_ok = (wr_data[15:`SCC_CUR_HI + 1] == 3'h0) &&
                  (wr_data[`SCC_CUR_HI:`SCC_CUR_LO] >= `SCC_CUR_MIN_CODE);
  // next register values
  always_comb begin
    opt_d = opt_q;
    cur_d = cur_q;
    volt_d = volt_q;
    inc_d = inc_q;
    tick_d = tick ? 18'h0 : tick_q + 18'h1;
    // learn ends by itself once the battery is depleted
    if (opt_q[`SCC_OPT_LEARN] && below_s) begin
      opt_d[`SCC_OPT_LEARN] = 1'b0; // see RL21 see RL22
    end
    if (hit(wr_fire, cmd_q, `SCC_CMD_OPT)) begin
      opt_d = wr_data; // see RL9 see RL20 see RL22
    end
    if (hit(wr_fire, cmd_q, `SCC_CMD_CUR)) begin
      cur_d = cur_ok ? (wr_data & `SCC_CUR_MASK) : 16'h0000; // see RL10 see RL23
    end
    if (hit(wr_fire, cmd_q, `SCC_CMD_VOLT)) begin
      volt_d = wr_data & `SCC_VOLT_MASK; // see RL11
    end
    if (hit(wr_fire, cmd_q, `SCC_CMD_INCUR)) begin
      inc_d = wr_data & `SCC_INCUR_MASK; // see RL12
    end
    // identity commands have no storage, writes fall away: see RL25
    adapter_present_flag_d = degl_exp & det_s;
    // learn hands the system to the battery
    acsw_d = adapter_present_flag_q & ~opt_q[`SCC_OPT_LEARN]; // see RL21
    cycled_d = cycled_q | (acsw_q & ~acsw_d); // see RL15
    // a restart this cycle overrides an old expiry
    chg_d = (cur_d != 16'h0000) && !opt_d[`SCC_OPT_INHIBIT] &&
            (!wd_exp || wd_restart); // see RL18 see RL19 see RL23
  end
  // register update
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      opt_q <= `SCC_OPT_RST;
      cur_q <= `SCC_CUR_RST;
      volt_q <= `SCC_VOLT_RST;
      inc_q <= `SCC_INCUR_RST;
      tick_q <= 18'h0;
      adapter_present_flag_q <= 1'b0;
      acsw_q <= 1'b0;
      cycled_q <= 1'b0;
      chg_q <= 1'b0;
    end else begin
      opt_q <= opt_d;
      cur_q <= cur_d;
      volt_q <= volt_d;
      inc_q <= inc_d;
      tick_q <= tick_d;
      adapter_present_flag_q <= adapter_present_flag_d;
      acsw_q <= acsw_d;
      cycled_q <= cycled_d;
      chg_q <= chg_d;
    end
  end
  assign settings = '{opt_q, cur_q, volt_q, inc_q};
  assign power = '{adapter_present_flag_q, acsw_q, ~acsw_q, chg_q};
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_b);
  idle_quiet_a: assert property (st_q == ST_IDLE |-> !oe_q) // see RL1
    else $error("sda driven while idle");
  disabled_bus_a: assert property (!bus_en |=> st_q == ST_IDLE && !oe_q) // see RL3
    else $error("bus answered while disabled");
  start_seen_a: assert property (start_ev && bus_en |=> st_q == ST_RX && bit_q == 4'h0) // see RL4
    else $error("start not taken");
  stop_seen_a: assert property (stop_ev |=> st_q == ST_IDLE) // see RL4
    else $error("stop not taken");
  addr_ack_a: assert property (st_q == ST_RX && byte_q == 3'h0 && bit_q == 4'h8 && scl_fall
    && shift_q[7:1] == `SCC_SLAVE_ADDR && bus_en && !stop_ev |=> oe_q ##0 st_q == ST_ACK) // see RL7
    else $error("own address not acked");
  word_commit_a: assert property (wr_fire |-> oe_q && $past(st_q) == ST_ACK && byte_q == 3'h3) // see RL24
    else $error("word committed outside high ack");
  cur_range_a: assert property (hit(wr_fire, cmd_q, `SCC_CMD_CUR) && !cur_ok
    |=> cur_q == 16'h0000 ##1 !chg_q) // see RL23
    else $error("bad current kept");
  wd_suspend_a: assert property (wd_exp && !wd_restart |=> !chg_q) // see RL18
    else $error("charging past watchdog");
  wd_restart_a: assert property (wd_restart |=> !wd_exp) // see RL17
    else $error("watchdog not restarted");
  learn_end_a: assert property (opt_q[`SCC_OPT_LEARN] && below_s && !wr_fire
    |=> !opt_q[`SCC_OPT_LEARN] ##1 acsw_q == $past(adapter_present_flag_q)) // see RL21
    else $error("learn did not end");
  first_short_a: assert property (!cycled_q |-> degl_limit == `SCC_DEGL_SHORT_TK) // see RL15
    else $error("long deglitch before cycle");
endmodule

// ---- sim/scc_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// smbus host model
// ----------------------------------------
module scc_host_model (
  input wire logic sda_wire,
  output logic scl_pin,
  output logic sda_low
);
  localparam time QTR = 12; // quarter of a 48 ns bus clock
  // idle bus: clock parked high, data left to the pull-up
  initial begin
    scl_pin = 1'b1;
    sda_low = 1'b0;
  end
  // one clock; data moves a quarter after the fall so it never races it
  task automatic clk_bit(input logic drv, output logic smp);
    sda_low = ~drv;
    #QTR scl_pin = 1'b1;
    #QTR smp = sda_wire;
    #QTR scl_pin = 1'b0;
    #QTR;
  endtask
  // start or repeated start: data falls with clock high
  task automatic bus_start();
    sda_low = 1'b0;
    #QTR scl_pin = 1'b1;
    #QTR sda_low = 1'b1;
    #QTR scl_pin = 1'b0;
    #QTR;
  endtask
  // stop: data rises with clock high, clock then stands still
  task automatic bus_stop();
    sda_low = 1'b1;
    #QTR scl_pin = 1'b1;
    #QTR sda_low = 1'b0;
    #(4 * QTR);
  endtask
  // byte out msb first, ninth clock released for the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, ack);
  endtask
  // byte in, then ack low or nack high on the ninth clock
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, b[i]);
    end
    clk_bit(nack, s);
  endtask
  // write word: address, command, low, high, stop
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, output logic [3:0] a);
    bus_start();
    send_byte(8'h12, a[3]);
    send_byte(cmd, a[2]);
    send_byte(d[7:0], a[1]);
    send_byte(d[15:8], a[0]);
    bus_stop();
  endtask
  // read word: command, restart, low byte acked, high byte nacked
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic [2:0] a);
    bus_start();
    send_byte(8'h12, a[2]);
    send_byte(cmd, a[1]);
    bus_start();
    send_byte(8'h13, a[0]);
    recv_byte(1'b0, d[7:0]);
    recv_byte(1'b1, d[15:8]);
    bus_stop();
  endtask
endmodule

// ---- sim/scc_top_tb_top.sv ----
`timescale 1ns/1ps
module scc_top_tb_top;
  import scc_pkg::*;
  localparam logic [15:0] MAKER = 16'h3c5a; // arbitrary value
  localparam logic [15:0] PART = 16'h0a71; // arbitrary value
  logic ref_clk;
  logic rst_b;
  logic supply_valid;
  logic adapter_detect_input;
  logic battery_below_depletion;
  logic scl_pin;
  logic sda_low;
  logic sda_pin_out;
  logic sda_pin_oe;
  scc_settings_t settings;
  scc_power_t power;
  int n_fail;
  int n_checks;
  logic a; // raw ack sample
  // register table and current write cases
  logic [7:0] cmds [6] = '{8'h12, 8'h14, 8'h15, 8'h3f, 8'hfe, 8'hff};
  logic [15:0] rsts [6] = '{16'h7904, 16'h0000, 16'h0000, 16'h1000, MAKER, PART};
  logic [15:0] cur_wr [4] = '{16'h0400, 16'h0040, 16'h2000, 16'h1fff};
  logic [15:0] cur_ex [4] = '{16'h0400, 16'h0000, 16'h0000, 16'h1fc0};
  // open-drain wire: low if either side pulls, pull-up otherwise
  wire logic sda_wire = ~sda_low & ~(sda_pin_oe & ~sda_pin_out);
  // ----------------------------------------
  // design and host
  // ----------------------------------------
  scc_top #(.TICK_CYCLES(1), .MAKER_ID(MAKER), .PART_ID(PART)) dut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .scl_pin(scl_pin),
    .sda_pin_in(sda_wire),
    .sda_pin_out(sda_pin_out),
    .sda_pin_oe(sda_pin_oe),
    .supply_valid(supply_valid),
    .adapter_detect_input(adapter_detect_input),
    .battery_below_depletion(battery_below_depletion),
    .settings(settings),
    .power(power)
  );
  scc_host_model host (.sda_wire(sda_wire), .scl_pin(scl_pin), .sda_low(sda_low));
  // 250 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // power order: flag, adapter switch, battery switch, charge enable
  // look off the edge that updates it, then realign to the rising edge
  task automatic pw(input logic [3:0] exp);
    @(negedge ref_clk);
    check({12'h000, power}, {12'h000, exp});
    @(posedge ref_clk);
  endtask
  task automatic reg_write(input logic [7:0] cmd, input logic [15:0] d);
    logic [3:0] acks;
    host.write_word(cmd, d, acks);
    cycles(1);
    check({12'h000, acks}, 16'h0000);
  endtask
  task automatic reg_read(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] d;
    logic [2:0] acks;
    host.read_word(cmd, d, acks);
    cycles(1);
    check({13'h0000, acks}, 16'h0000);
    check(d, exp);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst_b = 1'b0;
    supply_valid = 1'b1;
    adapter_detect_input = 1'b1;
    battery_below_depletion = 1'b0;
    cycles(10);
    check(settings[63:48], 16'h7904);
    check(settings[47:32], 16'h0000);
    check(settings[31:16], 16'h0000);
    check(settings[15:0], 16'h1000);
    rst_b <= 1'b1;
    // first plug-in after reset takes the short deglitch
    cycles(100);
    pw(4'b0010);
    cycles(100);
    pw(4'b1100);
    for (int i = 0; i < 6; i++) begin
      reg_read(cmds[i], rsts[i]);
    end
    // long deglitch once the adapter switch has cycled
    reg_write(8'h12, 16'hf904);
    adapter_detect_input <= 1'b0;
    cycles(20);
    pw(4'b0010);
    adapter_detect_input <= 1'b1;
    cycles(600);
    pw(4'b0010);
    cycles(800);
    pw(4'b1100);
    // identity words ignore writes; unmapped reads give zero
    reg_write(8'hfe, 16'hffff);
    reg_read(8'hfe, MAKER);
    reg_write(8'hff, 16'h0000);
    reg_read(8'hff, PART);
    reg_read(8'h20, 16'h0000);
    reg_write(8'h15, 16'h1234);
    reg_read(8'h15, 16'h1230);
    reg_write(8'h3f, 16'h0fff);
    reg_read(8'h3f, 16'h0f80);
    // frame cut after the low byte commits nothing
    host.bus_start();
    host.send_byte(8'h12, a);
    host.send_byte(8'h15, a);
    host.send_byte(8'h55, a);
    host.bus_stop();
    reg_read(8'h15, 16'h1230);
    // foreign address is not acknowledged
    host.bus_start();
    host.send_byte(8'h14, a);
    host.bus_stop();
    check({15'h0000, a}, 16'h0001);
    cycles(1);
    // interface silent while the supply is invalid
    supply_valid <= 1'b0;
    cycles(5);
    host.bus_start();
    host.send_byte(8'h12, a);
    host.bus_stop();
    check({15'h0000, a}, 16'h0001);
    cycles(1);
    supply_valid <= 1'b1;
    cycles(5);
    // current range: out-of-range codes clear and stop charging
    for (int i = 0; i < 4; i++) begin
      reg_write(8'h14, cur_wr[i]);
      reg_read(8'h14, cur_ex[i]);
      check({15'h0000, power.charge_enable}, {15'h0000, cur_ex[i] != 16'h0000});
    end
    // learn cycle: battery feeds system until depletion
    reg_write(8'h12, 16'hf944);
    cycles(4);
    pw(4'b1011);
    reg_write(8'h12, 16'hf904);
    cycles(4);
    pw(4'b1101);
    reg_write(8'h12, 16'hf944);
    battery_below_depletion <= 1'b1;
    cycles(10);
    pw(4'b1101);
    check(settings[63:48], 16'hf904);
    battery_below_depletion <= 1'b0;
    // watchdog at 44000 ticks, restarted by current or voltage writes
    reg_write(8'h12, 16'h3904);
    reg_write(8'h14, 16'h0400);
    cycles(25000);
    pw(4'b1101);
    reg_write(8'h15, 16'h1230);
    cycles(25000);
    pw(4'b1101);
    cycles(20000);
    pw(4'b1100);
    reg_write(8'h15, 16'h1230);
    cycles(4);
    pw(4'b1101);
    close_out();
  end
endmodule
